// ==== rtl/irc_defines.svh ====
// Offsets, field positions, reset values and clock ratios of the IR carrier timer.
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH
`define IRC_PER_COUNT 8'h05
`define IRC_PER_LIMIT 8'h06
`define IRC_PER_HIGH 8'h07
`define IRC_PER_LOW 8'h08
`define IRC_RF_BUFEN 7'h11
`define IRC_RF_LIVEEN 7'h12
`define IRC_RF_CTRL 7'h33
`define IRC_RF_FLAG 7'h3f
`define IRC_CTRL_RUN 3
`define IRC_CTRL_CLEAR 2
`define IRC_LOW_SEL_BIT 7
`define IRC_CLKSEL_DIV32 2'h0
`define IRC_CLKSEL_DIV64 2'h1
`define IRC_CLKSEL_DIV256 2'h2
`define IRC_CLKSEL_CARRIER 2'h3
`define IRC_LOG_DIV32 4'h5
`define IRC_LOG_DIV64 4'h6
`define IRC_LOG_DIV256 4'h8
`define IRC_COUNT_RESET 8'h00
`define IRC_LIMIT_RESET 8'hff
`define IRC_HIGH_RESET 7'h00
`define IRC_LOW_RESET 8'h00
`define IRC_CLKSEL_RESET 2'h0
`endif

// ==== rtl/irc_pkg.sv ====
// Types shared by the IR carrier timer modules.
package irc_pkg;
  typedef enum logic {
    PH_HIGH,
    PH_LOW
  } irc_phase_type;
  typedef struct packed {
    logic run;
    logic [1:0] clksel;
  } irc_ctrl_type;
  typedef struct packed {
    logic [6:0] high_period;
    logic [7:0] low_period;
  } irc_carrier_cfg_type;
endpackage : irc_pkg

// ==== rtl/irc_carrier.sv ====
// Carrier generator: one 7-bit counter alternating between high and low period limits.
`timescale 1ns/1ps
module irc_carrier #(
  parameter bit RATE_DIV2 = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input irc_pkg::irc_carrier_cfg_type cfg,
  output logic level,
  output logic cycle_end
);
  import irc_pkg::*;
  irc_phase_type phase, next_phase;
  logic [6:0] cnt, next_cnt;
  logic div, next_div;
  logic next_level;
  logic next_end;

  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_div = div;
    next_end = 1'b0;
    if (!run) begin
      // Halted generator restarts cleanly at the beginning of a high phase.
      next_phase = PH_HIGH;
      next_cnt = 7'h00;
      next_div = 1'b0;
    end else if (phase == PH_HIGH && !level) begin
      // The first running cycle only raises the output, so the first high phase is not cut short.
      next_phase = PH_HIGH;
    end else begin
      next_div = RATE_DIV2 ? ~div : 1'b0;
      if (!RATE_DIV2 || div) begin
        case (phase)
          PH_HIGH: begin
            if (cnt == cfg.high_period) begin
              next_cnt = 7'h00;
              next_phase = PH_LOW;
            end else begin
              next_cnt = cnt + 7'h01;
            end
          end
          PH_LOW: begin
            if (cnt == cfg.low_period[6:0]) begin
              next_cnt = 7'h00;
              next_phase = PH_HIGH;
              next_end = 1'b1;
            end else begin
              next_cnt = cnt + 7'h01;
            end
          end
          default: next_phase = PH_HIGH;
        endcase
      end
    end
    next_level = run && (next_phase == PH_HIGH);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= PH_HIGH;
      cnt <= 7'h00;
      div <= 1'b0;
      level <= 1'b0;
      cycle_end <= 1'b0;
    end else if (ce) begin
      phase <= next_phase;
      cnt <= next_cnt;
      div <= next_div;
      level <= next_level;
      cycle_end <= next_end;
    end
  end

  // Length check counts clock cycles spent in each level and compares the high span only.
  logic [8:0] len;
  logic [8:0] hi_want;
  logic [8:0] lo_want;
  assign hi_want = 9'({2'h0, cfg.high_period} + 9'h001) << (RATE_DIV2 ? 1 : 0);
  assign lo_want = 9'({2'h0, cfg.low_period[6:0]} + 9'h001) << (RATE_DIV2 ? 1 : 0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      len <= 9'h000;
    end else if (ce) begin
      len <= (level != next_level) ? 9'h001 : 9'(len + 9'h001);
    end
  end

  property p_high_len;
    @(posedge clk) disable iff (rst)
      ce && run && level && !next_level && $stable(cfg) |-> len == hi_want;
  endproperty
  a_high_len: assert property (p_high_len) else $error("carrier high length wrong");

  property p_halt_low;
    @(posedge clk) disable iff (rst) ce && !run |=> !level;
  endproperty
  a_halt_low: assert property (p_halt_low) else $error("halted carrier not low");
endmodule : irc_carrier

// ==== rtl/irc_timer.sv ====
// 8-bit modulo timer with IR carrier output control, reached through peripheral and register-file ports.
// Operation
// - Timer counts a prescaled clock or carrier cycles, picked by the two low control bits.
// - Control bit 3 runs the timer; writing one to bit 2 clears count.
// - Clear bit acts on write only and always reads back as zero.
// - Count reads at peripheral 05H, resets to 00H, cannot be loaded.
// - Limit at peripheral 06H is write-only, resets to FFH.
// - Match flag at file address 3FH bit 0 sets on count equal to a nonzero limit.
// - Carrier uses a 7-bit counter against high and low period limits.
// - Carrier clock is fx/2 or fx, fixed by a build option.
// - Both carrier period registers are writable and readable.
// - Low-period bit 7 set sends steady high instead of the carrier.
// - Pin follows carrier while live enable is one, else low.
// - Each timer match copies buffered enable into live enable.
// - Match during high carrier with live enable one waits for carrier low before applying enable.
// - Carrier halts while live enable is zero unless timer uses it.
// - Clock select 11 may shorten or delay the first high pulse.
// - High lasts high value plus one clocks, low likewise.
// - Timer clock follows instruction speed mode; switching shifts one step.
`timescale 1ns/1ps
`include "irc_defines.svh"
module irc_timer #(
  parameter bit RATE_DIV2 = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic high_speed_mode,
  input wire logic stop_mode,
  input wire logic [7:0] per_addr,
  input wire logic per_put,
  input wire logic per_get,
  input wire logic [7:0] transfer_buffer_in,
  output logic [7:0] transfer_buffer_out,
  input wire logic [6:0] rf_addr,
  input wire logic rf_write,
  input wire logic [3:0] rf_wdata,
  output logic [3:0] rf_rdata,
  input wire logic match_ack,
  output logic timer_match_flag,
  output logic remote_output_pin
);
  import irc_pkg::*;

  // A count tick fires when the low log2(ratio) prescaler bits are all ones.
  function automatic logic pre_tick(input logic [7:0] pre, input logic [3:0] lg);
    logic [7:0] mask;
    mask = 8'((9'h001 << lg) - 9'h001);
    return (pre & mask) == mask;
  endfunction : pre_tick

  irc_ctrl_type ctrl, next_ctrl;
  irc_carrier_cfg_type cfg, next_cfg;
  logic [7:0] pre, next_pre;
  logic [7:0] timer_count_value, next_count;
  logic [7:0] timer_match_limit, next_limit;
  logic next_flag;
  logic buffered_output_enable, next_buf_en;
  logic live_en, next_live_en;
  logic pending, next_pending;
  logic pend_val, next_pend_val;
  logic next_pin;
  logic [7:0] next_tbuf;
  logic [3:0] next_rdata;
  logic tick, count_tick, hit;
  logic [3:0] hs_sub;
  logic car_level, car_end, car_run;
  logic ctrl_wr, flag_wr, buf_wr, live_wr;

  assign ctrl_wr = rf_write && (rf_addr == `IRC_RF_CTRL);
  assign flag_wr = rf_write && (rf_addr == `IRC_RF_FLAG);
  assign buf_wr = rf_write && (rf_addr == `IRC_RF_BUFEN);
  assign live_wr = rf_write && (rf_addr == `IRC_RF_LIVEEN);

  // Timer group: prescaler, control, limit, counter and match flag.
  always_comb begin
    next_pre = pre + 8'h01;
    hs_sub = {3'h0, high_speed_mode};
    case (ctrl.clksel)
      `IRC_CLKSEL_DIV32: tick = pre_tick(pre, 4'(`IRC_LOG_DIV32 - hs_sub));
      `IRC_CLKSEL_DIV64: tick = pre_tick(pre, 4'(`IRC_LOG_DIV64 - hs_sub));
      `IRC_CLKSEL_DIV256: tick = pre_tick(pre, 4'(`IRC_LOG_DIV256 - hs_sub));
      default: tick = car_end;
    endcase
    count_tick = ctrl.run && tick;
    // A zero limit would match on every tick; it is kept silent instead.
    hit = count_tick && (timer_count_value == timer_match_limit)
          && (timer_match_limit != 8'h00);
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.run = rf_wdata[`IRC_CTRL_RUN];
      next_ctrl.clksel = rf_wdata[1:0];
    end
    if (stop_mode) begin
      next_ctrl.run = 1'b0;
    end
    next_limit = timer_match_limit;
    if (per_put && (per_addr == `IRC_PER_LIMIT)) begin
      next_limit = transfer_buffer_in;
    end
    next_count = timer_count_value;
    if (ctrl_wr && rf_wdata[`IRC_CTRL_CLEAR]) begin
      next_count = `IRC_COUNT_RESET;
    end else if (count_tick) begin
      if (timer_count_value == timer_match_limit) begin
        next_count = 8'h00;
      end else begin
        next_count = timer_count_value + 8'h01;
      end
    end
    // A new match wins over a clear in the same cycle.
    next_flag = timer_match_flag;
    if (match_ack || (flag_wr && !rf_wdata[0])) begin
      next_flag = 1'b0;
    end
    if (flag_wr && rf_wdata[0]) begin
      next_flag = 1'b1;
    end
    if (hit) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= 8'h00;
      ctrl <= '{run: 1'b0, clksel: `IRC_CLKSEL_RESET};
      timer_match_limit <= `IRC_LIMIT_RESET;
      timer_count_value <= `IRC_COUNT_RESET;
      timer_match_flag <= 1'b0;
    end else if (ce) begin
      pre <= next_pre;
      ctrl <= next_ctrl;
      timer_match_limit <= next_limit;
      timer_count_value <= next_count;
      timer_match_flag <= next_flag;
    end
  end

  // Output-enable group: buffered and live enables, carrier setup and pin.
  always_comb begin
    next_cfg = cfg;
    if (per_put && (per_addr == `IRC_PER_HIGH)) begin
      next_cfg.high_period = transfer_buffer_in[6:0];
    end
    if (per_put && (per_addr == `IRC_PER_LOW)) begin
      next_cfg.low_period = transfer_buffer_in;
    end
    next_buf_en = buf_wr ? rf_wdata[0] : buffered_output_enable;
    next_live_en = live_en;
    next_pending = pending;
    next_pend_val = pend_val;
    if (pending && !car_level) begin
      next_live_en = pend_val;
      next_pending = 1'b0;
    end
    if (hit) begin
      // Holding the update keeps the last carrier high pulse full width.
      if (live_en && car_level) begin
        next_pending = 1'b1;
        next_pend_val = buffered_output_enable;
      end else begin
        next_live_en = buffered_output_enable;
        next_pending = 1'b0;
      end
    end
    if (live_wr) begin
      // A direct write may cut the first high pulse short.
      next_live_en = rf_wdata[0];
      next_pending = 1'b0;
    end
    next_pin = live_en && (cfg.low_period[`IRC_LOW_SEL_BIT] || car_level);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= '{high_period: `IRC_HIGH_RESET, low_period: `IRC_LOW_RESET};
      buffered_output_enable <= 1'b0;
      live_en <= 1'b0;
      pending <= 1'b0;
      pend_val <= 1'b0;
      remote_output_pin <= 1'b0;
    end else if (ce) begin
      cfg <= next_cfg;
      buffered_output_enable <= next_buf_en;
      live_en <= next_live_en;
      pending <= next_pending;
      pend_val <= next_pend_val;
      remote_output_pin <= next_pin;
    end
  end

  // The timer may use the carrier as its clock, so it must keep running then.
  assign car_run = live_en || (ctrl.clksel == `IRC_CLKSEL_CARRIER);

  irc_carrier #(
    .RATE_DIV2(RATE_DIV2)
  ) u_carrier (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(car_run),
    .cfg(cfg),
    .level(car_level),
    .cycle_end(car_end)
  );

  // Read group: peripheral data buffer and register-file read data.
  always_comb begin
    next_tbuf = transfer_buffer_out;
    if (per_get) begin
      case (per_addr)
        `IRC_PER_COUNT: next_tbuf = timer_count_value;
        `IRC_PER_HIGH: next_tbuf = {1'b0, cfg.high_period};
        `IRC_PER_LOW: next_tbuf = cfg.low_period;
        default: next_tbuf = 8'h00;
      endcase
    end
    case (rf_addr)
      `IRC_RF_CTRL: next_rdata = {ctrl.run, 1'b0, ctrl.clksel};
      `IRC_RF_FLAG: next_rdata = {3'h0, timer_match_flag};
      `IRC_RF_BUFEN: next_rdata = {3'h0, buffered_output_enable};
      `IRC_RF_LIVEEN: next_rdata = {3'h0, live_en};
      default: next_rdata = 4'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_buffer_out <= 8'h00;
      rf_rdata <= 4'h0;
    end else if (ce) begin
      transfer_buffer_out <= next_tbuf;
      rf_rdata <= next_rdata;
    end
  end

  sequence s_match;
    ce && hit;
  endsequence

  sequence s_flag_up;
    timer_match_flag && (timer_count_value == 8'h00);
  endsequence

  property p_match_flag;
    @(posedge clk) disable iff (rst) s_match |=> s_flag_up;
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

  property p_zero_limit;
    @(posedge clk) disable iff (rst)
      ce && !timer_match_flag && timer_match_limit == 8'h00 && !flag_wr |=> !timer_match_flag;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("zero limit raised flag");

  property p_copy_enable;
    @(posedge clk) disable iff (rst)
      ce && hit && !(live_en && car_level) && !live_wr |=> live_en == $past(buffered_output_enable);
  endproperty
  a_copy_enable: assert property (p_copy_enable) else $error("enable not copied on match");

  property p_pin_low;
    @(posedge clk) disable iff (rst) ce && !live_en |=> !remote_output_pin;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not low while disabled");

  property p_steady_high;
    @(posedge clk) disable iff (rst)
      ce && live_en && cfg.low_period[`IRC_LOW_SEL_BIT] |=> remote_output_pin;
  endproperty
  a_steady_high: assert property (p_steady_high) else $error("steady high not output");

  property p_clear_count;
    @(posedge clk) disable iff (rst)
      ce && ctrl_wr && rf_wdata[`IRC_CTRL_CLEAR] |=> timer_count_value == 8'h00 ##1 rf_rdata[2] == 1'b0;
  endproperty
  a_clear_count: assert property (p_clear_count) else $error("clear bit misbehaved");

  property p_count_read;
    @(posedge clk) disable iff (rst)
      ce && per_get && per_addr == `IRC_PER_COUNT |=> transfer_buffer_out == $past(timer_count_value);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong");

  property p_limit_hidden;
    @(posedge clk) disable iff (rst)
      ce && per_get && per_addr == `IRC_PER_LIMIT |=> transfer_buffer_out == 8'h00;
  endproperty
  a_limit_hidden: assert property (p_limit_hidden) else $error("limit readable");

  property p_hold_high;
    @(posedge clk) disable iff (rst)
      ce && hit && live_en && car_level && !live_wr |=> live_en && pending;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("enable changed during high");

  property p_stopped;
    @(posedge clk) disable iff (rst)
      ce && !ctrl.run && !ctrl_wr |=> $stable(timer_count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer counted");
endmodule : irc_timer

// ==== test/irc_led_model.sv ====
// Infrared LED model that measures the lit and dark spans on the remote output pin.
`timescale 1ns/1ps
module irc_led_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drive,
  output logic lit,
  output logic [7:0] on_len,
  output logic [7:0] off_len
);
  logic [7:0] run_len;
  // The LED only sinks current, so it answers nothing and just records spans in clock cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lit <= 1'b0;
      run_len <= 8'h01;
      on_len <= 8'h00;
      off_len <= 8'h00;
    end else begin
      lit <= drive;
      if (drive !== lit) begin
        run_len <= 8'h01;
        if (lit) begin
          on_len <= run_len;
        end else begin
          off_len <= run_len;
        end
      end else begin
        run_len <= run_len + 8'h01;
      end
    end
  end
endmodule : irc_led_model

// ==== test/tb.sv ====
// Self-checking bench for the IR carrier timer with an LED on its output pin.
`timescale 1ns/1ps
module tb;
  import irc_pkg::*;
  localparam bit RATE = 1'b1;
  logic clk, rst, stop_mode, per_put, per_get, rf_write, match_ack, timer_match_flag, remote_output_pin;
  logic [7:0] per_addr, transfer_buffer_in, transfer_buffer_out, on_len, off_len, h, l, lim;
  logic [6:0] rf_addr;
  logic [3:0] rf_wdata, rf_rdata;
  logic lit, ce, hs;
  logic flag_q = 1'b0;
  logic [15:0] gap = 16'h0000;
  logic [15:0] period = 16'h0000;
  int rises = 0;
  int n_errors, num_checks, seed, k;

  irc_timer #(.RATE_DIV2(RATE)) u_dut (.clk(clk), .rst(rst), .ce(ce), .high_speed_mode(hs),
    .stop_mode(stop_mode), .per_addr(per_addr), .per_put(per_put), .per_get(per_get),
    .transfer_buffer_in(transfer_buffer_in), .transfer_buffer_out(transfer_buffer_out),
    .rf_addr(rf_addr), .rf_write(rf_write), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
    .match_ack(match_ack), .timer_match_flag(timer_match_flag), .remote_output_pin(remote_output_pin));
  irc_led_model u_led (.clk(clk), .rst(rst), .drive(remote_output_pin), .lit(lit), .on_len(on_len),
    .off_len(off_len));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Takes each new flag at once, so the spacing of flag rises equals the match period.
  always @(posedge clk) begin
    flag_q <= timer_match_flag;
    match_ack <= timer_match_flag & ~flag_q;
    if (timer_match_flag & ~flag_q) begin
      period <= gap;
      gap <= 16'h0001;
      rises <= rises + 1;
    end else begin
      gap <= gap + 16'h0001;
    end
  end

  function automatic logic [15:0] span(input logic [7:0] v);
    return (16'(v) + 16'h0001) * (RATE ? 16'h0002 : 16'h0001);
  endfunction : span

  function automatic logic [15:0] match_period(input logic [7:0] v, input int sel);
    // Code 3 counts whole carrier cycles, whose length follows from the period registers.
    return (16'(v) + 16'h0001) * (sel == 3 ? 16'(span(h) + span(l)) :
      (sel == 0 ? 16'h0020 : (sel == 1 ? 16'h0040 : 16'h0100)));
  endfunction : match_period

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic pput(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    per_addr <= a;
    transfer_buffer_in <= d;
    per_put <= 1'b1;
    @(posedge clk);
    per_put <= 1'b0;
  endtask : pput

  task automatic pget(input logic [7:0] a);
    @(posedge clk);
    per_addr <= a;
    per_get <= 1'b1;
    @(posedge clk);
    per_get <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pget

  task automatic rfw(input logic [6:0] a, input logic [3:0] d);
    @(posedge clk);
    rf_addr <= a;
    rf_wdata <= d;
    rf_write <= 1'b1;
    @(posedge clk);
    rf_write <= 1'b0;
  endtask : rfw

  task automatic rfr(input logic [6:0] a);
    @(posedge clk);
    rf_addr <= a;
    repeat (2) @(posedge clk);
    #1;
  endtask : rfr

  task automatic wait_rises(input int n);
    int target;
    int cnt;
    target = rises + n;
    cnt = 0;
    while (rises < target && cnt < 4000) begin
      @(posedge clk);
      cnt++;
    end
    if (rises < target) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, rises, target);
    end
  endtask : wait_rises

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(20000 * 50);
    n_errors++;
    print_verdict();
  end

  initial begin
    seed = 32'h3b6615f6;
    rst = 1'b1;
    stop_mode = 1'b0;
    per_put = 1'b0;
    per_get = 1'b0;
    rf_write = 1'b0;
    per_addr = 8'h00;
    transfer_buffer_in = 8'h00;
    rf_addr = 7'h00;
    rf_wdata = 4'h0;
    ce = 1'b1;
    hs = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check(remote_output_pin, 1'b0);
    pput(8'h05, 8'h5a);
    pget(8'h05);
    check(transfer_buffer_out, 8'h00);
    pput(8'h06, 8'h33);
    pget(8'h06);
    check(transfer_buffer_out, 8'h00);
    rfr(7'h33);
    check(rf_rdata, 4'h0);
    rfr(7'h12);
    check(rf_rdata, 4'h0);
    $display("test reset done");
    for (k = 0; k < 2; k++) begin
      h = 8'($random(seed));
      l = 8'($random(seed));
      pput(8'h07, h);
      pput(8'h08, l);
      pget(8'h07);
      check(transfer_buffer_out, {1'b0, h[6:0]});
      pget(8'h08);
      check(transfer_buffer_out, l);
    end
    $display("test period registers done");
    h = 8'($random(seed)) & 8'h0f;
    l = 8'($random(seed)) & 8'h0f;
    pput(8'h07, h);
    pput(8'h08, l);
    rfw(7'h12, 4'h1);
    repeat (200) @(posedge clk);
    check(on_len, span(h));
    check(off_len, span(l));
    pput(8'h08, 8'h80 | l);
    repeat (60) @(posedge clk);
    check(remote_output_pin, 1'b1);
    repeat (40) @(posedge clk);
    check(lit, 1'b1);
    rfw(7'h12, 4'h0);
    repeat (4) @(posedge clk);
    check(remote_output_pin, 1'b0);
    $display("test carrier done");
    for (k = 0; k < 4; k++) begin
      lim = 8'h01 + (8'($random(seed)) & 8'h03);
      pput(8'h06, lim);
      rfw(7'h33, 4'hc | 4'(k));
      wait_rises(3);
      check(period, match_period(lim, k));
      rfw(7'h33, 4'h0);
    end
    hs <= 1'b1;
    rfw(7'h33, 4'hd);
    wait_rises(3);
    check(period, match_period(lim, 0));
    rfw(7'h33, 4'h0);
    hs <= 1'b0;
    $display("test timer periods done");
    pput(8'h06, 8'hff);
    rfw(7'h33, 4'h8);
    repeat (300) @(posedge clk);
    rfw(7'h33, 4'hc);
    rfr(7'h33);
    check(rf_rdata, 4'h8);
    pget(8'h05);
    check(transfer_buffer_out > 8'h01, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    stop_mode <= 1'b0;
    rfr(7'h33);
    check(rf_rdata, 4'h0);
    rfw(7'h33, 4'h8);
    rfr(7'h33);
    check(rf_rdata, 4'h8);
    pget(8'h05);
    lim = transfer_buffer_out;
    @(posedge clk);
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    pget(8'h05);
    check(8'(transfer_buffer_out - lim) > 8'h01, 1'b0);
    $display("test control done");
    pput(8'h06, 8'h03);
    rfw(7'h11, 4'h1);
    rfw(7'h33, 4'hc);
    wait_rises(1);
    rfr(7'h12);
    check(rf_rdata, 4'h1);
    repeat (4) @(posedge clk);
    check(remote_output_pin, 1'b1);
    pput(8'h08, l);
    rfw(7'h11, 4'h0);
    wait_rises(2);
    repeat (80) @(posedge clk);
    check(remote_output_pin, 1'b0);
    check(on_len, span(h));
    $display("test buffered enable done");
    print_verdict();
  end
endmodule : tb
